// file: hdl/msr_pkg.sv
// Package: constants and types of the module select and reset gate
package msr_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ            = 50_000_000;
  localparam int RESET_PULSE_NS    = 10_000;
  localparam int RESET_PULSE_CYC   = (RESET_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int RESET_HOLD_CYC    = 16;
  localparam int CNT_W             = 16;

  // ==========================================================
  // Reset values
  localparam logic RST_SEL_N       = 1'b1;
  localparam logic RST_MOD_RST_N   = 1'b1;
  localparam logic [7:0] DEF_SETTING = 8'h00;

  // ==========================================================
  // States
  typedef enum logic [2:0]
  {
    ST_RUN   = 3'b001,
    ST_PULSE = 3'b010,
    ST_RESET = 3'b100
  } msr_state_t;

  // ==========================================================
  // 2-wire pins as three signals each
  typedef struct packed
  {
    logic scl_in;
    logic sda_in;
  } msr_wire_in_t;

  typedef struct packed
  {
    logic sda_out;
    logic sda_oe;
    logic scl_out;
    logic scl_oe;
  } msr_wire_out_t;

endpackage

// file: hdl/msr_pulse_filter.sv
// Low pulse length filter for the reset input
`timescale 1ns/1ps
module msr_pulse_filter #(
  parameter int MIN_CYC = msr_pkg::RESET_PULSE_CYC
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Pin level, pull-up already applied
  input  wire logic level_n,
  // One-cycle pulse once the low time reaches the minimum
  output logic      fire
);
  logic [msr_pkg::CNT_W-1:0] count;
  wire                       long_low = (count == msr_pkg::CNT_W'(MIN_CYC));

  always_ff @(posedge clk)
  begin
    if (srst || level_n)
      count <= '0;
    else if (!long_low)
      count <= count + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      fire <= 1'b0;
    else
      fire <= !level_n && (count == msr_pkg::CNT_W'(MIN_CYC - 1));
  end
endmodule

// file: hdl/msr_gate.sv
// Module select gating of the 2-wire bus and long-pulse module reset
`timescale 1ns/1ps
// Function
// - Selected module answers 2-wire commands
// - Deselected module never acknowledges or drives bus
// - Select input pulled high internally
// - Reset input pulled high internally
// - Long low reset restores defaults fully
module msr_gate #(
  parameter int MIN_CYC  = msr_pkg::RESET_PULSE_CYC,
  parameter int HOLD_CYC = msr_pkg::RESET_HOLD_CYC
)
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Host control pins, with drive flag (low when undriven)
  input  wire logic                   module_select_n,
  input  wire logic                   module_select_driven,
  input  wire logic                   module_reset_n,
  input  wire logic                   module_reset_driven,
  // 2-wire pins at the connector
  input  wire msr_pkg::msr_wire_in_t  pin_in,
  output msr_pkg::msr_wire_out_t      pin_out,
  // Internal 2-wire engine side
  input  wire msr_pkg::msr_wire_out_t engine_out,
  output msr_pkg::msr_wire_in_t       engine_in,
  // Module state
  output logic                        selected,
  output logic                        module_reset,
  output logic [7:0]                  user_setting,
  input  wire logic                   setting_we,
  input  wire logic [7:0]             setting_wdata
);

  // ==========================================================
  // Pull-ups
  function automatic logic pulled_up
  (
    input logic driven,
    input logic level
  );
    return driven ? level : 1'b1;
  endfunction

  wire sel_n_eff = pulled_up(module_select_driven, module_select_n);
  wire rst_n_eff = pulled_up(module_reset_driven, module_reset_n);

  // ==========================================================
  // Reset pulse filter
  wire reset_fire;

  msr_pulse_filter #(
    .MIN_CYC (MIN_CYC)
  ) u_filter (
    .clk     (clk),
    .srst    (srst),
    .level_n (rst_n_eff),
    .fire    (reset_fire)
  );

  // ==========================================================
  // Reset sequencer
  msr_pkg::msr_state_t       state;
  msr_pkg::msr_state_t       next_state;

  logic [msr_pkg::CNT_W-1:0] hold;
  wire                       hold_done = (hold == msr_pkg::CNT_W'(HOLD_CYC - 1));
  wire [msr_pkg::CNT_W-1:0]  next_hold = hold_done ? hold : hold + 1'b1;

  always_comb
  begin
    next_state = state;
    unique case (state)
      msr_pkg::ST_RUN:
      begin
        if (!rst_n_eff)
          next_state = msr_pkg::ST_PULSE;
      end
      msr_pkg::ST_PULSE:
      begin
        if (reset_fire)
          next_state = msr_pkg::ST_RESET;
        else if (rst_n_eff)
          next_state = msr_pkg::ST_RUN;
      end
      msr_pkg::ST_RESET:
      begin
        if (hold_done && rst_n_eff)
          next_state = msr_pkg::ST_RUN;
      end
      default:
      begin
        next_state = msr_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= msr_pkg::ST_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || state != msr_pkg::ST_RESET)
    begin
      hold <= '0;
    end
    else
    begin
      hold <= next_hold;
    end
  end

  wire in_reset = (next_state == msr_pkg::ST_RESET);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      module_reset <= 1'b0;
    end
    else
    begin
      module_reset <= in_reset;
    end
  end

  // ==========================================================
  // User settings
  wire       setting_take      = setting_we && selected;
  wire [7:0] next_user_setting = setting_take ? setting_wdata : user_setting;

  always_ff @(posedge clk)
  begin
    if (srst || in_reset)
    begin
      user_setting <= msr_pkg::DEF_SETTING;
    end
    else
    begin
      user_setting <= next_user_setting;
    end
  end

  // ==========================================================
  // Open-drain drive decode
  function automatic logic pulls_low
  (
    input logic oe,
    input logic out
  );
    return oe && !out;
  endfunction

  // ==========================================================
  // Select gating
  wire next_selected = !sel_n_eff && !in_reset;
  wire next_sda_oe   = next_selected && pulls_low(engine_out.sda_oe, engine_out.sda_out);
  wire next_scl_oe   = next_selected && pulls_low(engine_out.scl_oe, engine_out.scl_out);

  msr_pkg::msr_wire_out_t next_pin_out;
  msr_pkg::msr_wire_in_t  next_engine_in;

  assign next_pin_out.sda_out = 1'b0;
  assign next_pin_out.sda_oe  = next_sda_oe;
  assign next_pin_out.scl_out = 1'b0;
  assign next_pin_out.scl_oe  = next_scl_oe;
  assign next_engine_in       = next_selected ? pin_in : '1;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      selected <= 1'b0;
    end
    else
    begin
      selected <= next_selected;
    end
  end

  // ==========================================================
  // Bus pin drivers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_out <= '0;
    end
    else
    begin
      pin_out <= next_pin_out;
    end
  end

  // ==========================================================
  // Bus levels seen by the engine
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      engine_in <= '1;
    end
    else
    begin
      engine_in <= next_engine_in;
    end
  end

endmodule

// file: tb/msr_gate_props.sv
// Checker of the select and reset gate
`timescale 1ns/1ps
module msr_gate_props #(parameter int MIN_CYC = msr_pkg::RESET_PULSE_CYC)
(
  // Clock and pins
  input wire logic                   clk,
  input wire logic                   srst,
  input wire logic                   module_select_n,
  input wire logic                   module_select_driven,
  input wire logic                   module_reset_n,
  input wire logic                   module_reset_driven,
  // Outputs
  input wire msr_pkg::msr_wire_out_t pin_out,
  input wire msr_pkg::msr_wire_in_t  engine_in,
  input wire logic                   selected,
  input wire logic                   module_reset,
  input wire logic [7:0]             user_setting
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire sel = module_select_driven && !module_select_n;
  wire rl  = module_reset_driven && !module_reset_n;
  int  cnt;
  always_ff @(posedge clk) cnt <= rl ? cnt + 1 : 0;
  property p_sel; sel && !rl && !$past(rl) && !$past(rl, 2) && !module_reset && !$past(module_reset) |=> selected; endproperty
  a_sel: assert property (p_sel) else $error("select ignored");
  property p_gate; !selected && !$past(selected) |-> pin_out == 4'h0 && engine_in == 2'h3; endproperty
  a_gate: assert property (p_gate) else $error("bus touched while idle");
  property p_pull; !module_select_driven |=> !selected; endproperty
  a_pull: assert property (p_pull) else $error("undriven select taken");
  property p_rpull; !module_reset_driven [*3] ##0 !module_reset |=> !module_reset; endproperty
  a_rpull: assert property (p_rpull) else $error("undriven reset taken");
  property p_long; cnt == MIN_CYC + 3 |-> module_reset && user_setting == 8'h00 && !selected; endproperty
  a_long: assert property (p_long) else $error("long reset missed");
  property p_short; $rose(module_reset) |-> $past(cnt) >= MIN_CYC - 1; endproperty
  a_short: assert property (p_short) else $error("short pulse taken");
endmodule
bind msr_gate msr_gate_props #(.MIN_CYC(MIN_CYC)) u_props (.*);

// file: tb/msr_host.sv
// Host model driving select and reset
`timescale 1ns/1ps
module msr_host
(
  // Clock
  input wire logic clk,
  // Pins
  output logic     sel_n,
  output logic     sel_drv,
  output logic     rst_n,
  output logic     rst_drv
);
  initial {sel_n, sel_drv, rst_n, rst_drv} = 4'h0;
  task automatic pick(input logic s);
    sel_drv <= 1'b1;
    sel_n   <= !s;
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse(input int n);
    {rst_drv, rst_n} <= 2'h2;
    repeat (n) @(posedge clk);
    rst_drv <= 1'b0;
  endtask
endmodule

// file: tb/tb.sv
// Bench of the select and reset gate
`timescale 1ns/1ps
module tb;
  logic clk, srst, we, sn, sd, rn, rd, sel, mrst;
  logic [7:0] wd, us, v;
  logic [31:0] rs = 32'h0000_4b92;
  msr_pkg::msr_wire_in_t pi, ei, ppi;
  msr_pkg::msr_wire_out_t eo, po, peo;
  logic [9:0] q[$];
  logic [9:0] ex;
  int fail_count = 0, n_compared = 0, cyc = 0;
  event chk;
  msr_host h (.clk(clk), .sel_n(sn), .sel_drv(sd), .rst_n(rn), .rst_drv(rd));
  msr_gate #(.MIN_CYC(4), .HOLD_CYC(2)) dut (.clk(clk), .srst(srst), .module_select_n(sn),
    .module_select_driven(sd), .module_reset_n(rn), .module_reset_driven(rd), .pin_in(pi),
    .pin_out(po), .engine_out(eo), .engine_in(ei), .selected(sel), .module_reset(mrst),
    .user_setting(us), .setting_we(we), .setting_wdata(wd));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  always @(posedge clk)
  begin
    rs <= xs(rs);
    {pi, eo} <= rs[5:0];
    {ppi, peo} <= {pi, eo};
    if (++cyc == 3000) print_verdict(1);
  end
  always @(chk)
  begin
    #1;
    ex = q.pop_front();
    cmp(ex);
    cmp_bus(ex[9]);
  end
  task automatic cmp(input logic [9:0] e);
    n_compared++;
    if ({sel, mrst, us} !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, {sel, mrst, us}, e);
    end
  endtask
  task automatic cmp_bus(input logic s);
    logic [5:0] x;
    x = s ? {1'b0, peo.sda_oe && !peo.sda_out, 1'b0, peo.scl_oe && !peo.scl_out, ppi} : 6'h03;
    n_compared++;
    if ({po, ei} !== x)
    begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, {po, ei}, x);
    end
  endtask
  task automatic note(input logic [9:0] e);
    q.push_back(e);
    repeat (6) @(posedge clk);
    ->chk;
  endtask
  task automatic wr(input logic [7:0] d);
    we <= 1'b1;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic print_verdict(input int t);
    fail_count += t;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    srst = 1'b1;
    we = 1'b0;
    wd = 8'h00;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    wr(8'h5a);
    note(10'h000);
    h.pick(1);
    v = rs[15:8] | 8'h01;
    wr(v);
    note({2'h2, v});
    h.pick(0);
    wr(~v);
    note({2'h0, v});
    h.pick(1);
    h.pulse(2);
    note({2'h2, v});
    h.pulse(9);
    note(10'h200);
    @(posedge clk);
    print_verdict(0);
  end
endmodule
